// file: logic/ldg_glue.sv
// LAN controller to host DMA glue: decode, end-of-frame latch, collision end-of-process, bus hold limit
`include "ldg_map.svh"

module ldg_glue (
  // Clock, reset, enable
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  // LAN controller handshakes
  input wire logic lan_rx_drq_in,
  input wire logic lan_tx_drq_in,
  input wire logic lan_eof_in,
  input wire logic lan_coll_in,
  input wire logic lan_irq_in,
  // Host DMA controller
  input wire logic dma_ack6_n_in,
  input wire logic dma_ack7_n_in,
  output logic dma_req6_out,
  output logic dma_req7_out,
  output logic end_of_process_strobe_out,
  // Host bus
  input wire logic [23:0] bus_addr_in,
  input wire logic bus_aen_in,
  input wire logic io_rd_n_in,
  input wire logic io_wr_n_in,
  input wire logic mem_wr_n_in,
  output logic [15:0] bus_rdata_out,
  output logic bus_rdata_oe_out,
  output logic lan_cs_out,
  output logic host_irq_line_out
);

  ldg_pkg::ldg_glue_s st_r;
  ldg_pkg::ldg_glue_s st_nxt;
  ldg_pkg::ldg_pins_t pins;
  ldg_pkg::ldg_word_t buf_data;
  logic buf_in_ready;
  logic buf_out_valid;
  logic buf_pop;
  logic buf_push;
  logic eof_edge;
  logic coll_edge;
  logic wr_done;
  logic rd_start;
  logic rd_end;
  logic rd_act;
  logic bus_busy;
  logic sel_lo;
  logic sel_hi;
  logic sel_stat;
  logic sel_lan;

  function automatic logic rise(input logic prev, input logic cur);
    rise = cur && !prev;
  endfunction : rise

  function automatic logic io_hit(input logic [23:0] addr, input logic [15:0] base, input logic [15:0] mask);
    io_hit = ((addr[15:0] & mask) == base);
  endfunction : io_hit

  assign pins[`LDG_P_RXDRQ] = lan_rx_drq_in;
  assign pins[`LDG_P_TXDRQ] = lan_tx_drq_in;
  assign pins[`LDG_P_EOF] = lan_eof_in;
  assign pins[`LDG_P_COLL] = lan_coll_in;
  assign pins[`LDG_P_DACK6_N] = dma_ack6_n_in;
  assign pins[`LDG_P_DACK7_N] = dma_ack7_n_in;
  assign pins[`LDG_P_IORD_N] = io_rd_n_in;
  assign pins[`LDG_P_IOWR_N] = io_wr_n_in;
  assign pins[`LDG_P_AEN] = bus_aen_in;
  assign pins[`LDG_P_MEMWR_N] = mem_wr_n_in;
  assign pins[`LDG_P_IRQ] = lan_irq_in;

  // Edges are taken between the second stage and its delayed copy
  assign eof_edge = rise(st_r.prev_pin[`LDG_P_EOF], st_r.s2_pin[`LDG_P_EOF]);
  assign coll_edge = rise(st_r.prev_pin[`LDG_P_COLL], st_r.s2_pin[`LDG_P_COLL]);
  assign wr_done = rise(st_r.prev_pin[`LDG_P_MEMWR_N], st_r.s2_pin[`LDG_P_MEMWR_N])
    && !st_r.s2_pin[`LDG_P_DACK7_N];
  assign rd_act = !st_r.s2_pin[`LDG_P_IORD_N] && !st_r.s2_pin[`LDG_P_AEN];
  assign rd_start = rise(st_r.s2_pin[`LDG_P_IORD_N], st_r.prev_pin[`LDG_P_IORD_N]);
  assign rd_end = rise(st_r.prev_pin[`LDG_P_IORD_N], st_r.s2_pin[`LDG_P_IORD_N]);
  assign bus_busy = !st_r.s2_pin[`LDG_P_DACK6_N] || !st_r.s2_pin[`LDG_P_DACK7_N];

  // DMA cycles drive AEN high, so latch and controller reads never collide with them
  assign sel_lan = io_hit(st_r.s2_addr, `LDG_LAN_IO_BASE, `LDG_LAN_IO_MASK);
  assign sel_lo = io_hit(st_r.s2_addr, `LDG_LATCH_LO_ADDR, 16'hFFFF);
  assign sel_hi = io_hit(st_r.s2_addr, `LDG_LATCH_HI_ADDR, 16'hFFFF);
  assign sel_stat = io_hit(st_r.s2_addr, `LDG_STATUS_ADDR, 16'hFFFF);

  // Reading the high half releases the entry; a new frame end overwrites a word still waiting for the buffer
  assign buf_pop = rd_end && !st_r.prev_pin[`LDG_P_AEN] && sel_hi;
  assign buf_push = st_r.pend_vld;

  ldg_buf u_buf (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .ce_in(ce_in),
    .in_valid_in(buf_push),
    .in_ready_out(buf_in_ready),
    .in_data_in(st_r.pend_word),
    .out_valid_out(buf_out_valid),
    .out_ready_in(buf_pop),
    .out_data_out(buf_data)
  );

  always_comb begin
    st_nxt = st_r;
    st_nxt.s1_pin = pins;
    st_nxt.s2_pin = st_r.s1_pin;
    st_nxt.prev_pin = st_r.s2_pin;
    st_nxt.s1_addr = bus_addr_in;
    st_nxt.s2_addr = st_r.s1_addr;

    // Receive write address; the trailer words land last
    if (wr_done) begin
      st_nxt.last_addr = st_r.s2_addr;
      if (st_r.word_cnt != 12'hFFF) begin
        st_nxt.word_cnt = st_r.word_cnt + 12'h001;
      end
    end

    // Pending word leaves once the buffer accepts it; a new frame end wins
    if (st_r.pend_vld && buf_in_ready) begin
      st_nxt.pend_vld = 1'b0;
    end
    if (eof_edge) begin
      st_nxt.pend_vld = 1'b1;
      st_nxt.pend_word = {(st_r.word_cnt >= `LDG_TRAILER_WORDS), st_r.last_addr};
      st_nxt.word_cnt = 12'h000;
    end

    // Collision end-of-process pulse
    unique case (st_r.eop_st)
      ldg_pkg::LDG_EOP_IDLE: begin
        if (coll_edge) begin
          st_nxt.eop_st = ldg_pkg::LDG_EOP_PULSE;
          st_nxt.eop = 1'b1;
          st_nxt.eop_cnt = 4'h0;
        end
      end
      ldg_pkg::LDG_EOP_PULSE: begin
        st_nxt.eop_cnt = st_r.eop_cnt + 4'h1;
        if (st_r.eop_cnt == 4'(`LDG_EOP_CYC - 1)) begin
          st_nxt.eop_st = ldg_pkg::LDG_EOP_WAIT;
          st_nxt.eop = 1'b0;
        end
      end
      ldg_pkg::LDG_EOP_WAIT: begin
        // One pulse per collision, not one per clock of it
        if (!st_r.s2_pin[`LDG_P_COLL]) begin
          st_nxt.eop_st = ldg_pkg::LDG_EOP_IDLE;
        end
      end
      default: begin
        st_nxt.eop_st = ldg_pkg::LDG_EOP_IDLE;
        st_nxt.eop = 1'b0;
      end
    endcase

    // Refresh is not seen here, so tenure is cut short and the bus rests
    if (st_r.hold_block) begin
      st_nxt.hold_cnt = 8'h00;
      if (bus_busy) begin
        st_nxt.rest_cnt = 8'h00;
      end else if (st_r.rest_cnt == 8'(`LDG_BUS_REST_CYC - 1)) begin
        st_nxt.hold_block = 1'b0;
        st_nxt.rest_cnt = 8'h00;
      end else begin
        st_nxt.rest_cnt = st_r.rest_cnt + 8'h01;
      end
    end else if (bus_busy) begin
      if (st_r.hold_cnt == 8'(`LDG_BUS_HOLD_CYC - 1)) begin
        st_nxt.hold_block = 1'b1;
        st_nxt.hold_cnt = 8'h00;
      end else begin
        st_nxt.hold_cnt = st_r.hold_cnt + 8'h01;
      end
    end else begin
      st_nxt.hold_cnt = 8'h00;
    end

    // Fixed channels; both wait while the bus rests, receive also while a frame end is pending
    st_nxt.drq6 = st_r.s2_pin[`LDG_P_TXDRQ] && !st_nxt.hold_block;
    st_nxt.drq7 = st_r.s2_pin[`LDG_P_RXDRQ] && !st_nxt.hold_block && !st_nxt.pend_vld;
    st_nxt.irq = st_r.s2_pin[`LDG_P_IRQ];

    // Controller select covers reads and writes from the processor only
    st_nxt.lan_cs = sel_lan && !st_r.s2_pin[`LDG_P_AEN]
      && (!st_r.s2_pin[`LDG_P_IORD_N] || !st_r.s2_pin[`LDG_P_IOWR_N]);

    // Read data captured at the start of the strobe, held to its end
    if (rd_start && !st_r.s2_pin[`LDG_P_AEN]) begin
      if (sel_lo) begin
        st_nxt.rdata = buf_data[15:0];
      end else if (sel_hi) begin
        st_nxt.rdata = {buf_out_valid, 6'h00, buf_data[24], buf_data[23:16]};
      end else if (sel_stat) begin
        st_nxt.rdata = {13'h0000, st_r.hold_block, st_r.pend_vld, buf_out_valid};
      end
    end
    st_nxt.rdata_oe = rd_act && (sel_lo || sel_hi || sel_stat);
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      st_r <= '0;
      st_r.s1_pin <= `LDG_PIN_RST;
      st_r.s2_pin <= `LDG_PIN_RST;
      st_r.prev_pin <= `LDG_PIN_RST;
      st_r.eop_st <= ldg_pkg::LDG_EOP_IDLE;
    end else if (ce_in) begin
      st_r <= st_nxt;
    end
  end

  assign dma_req6_out = st_r.drq6;
  assign dma_req7_out = st_r.drq7;
  assign end_of_process_strobe_out = st_r.eop;
  assign bus_rdata_out = st_r.rdata;
  assign bus_rdata_oe_out = st_r.rdata_oe;
  assign lan_cs_out = st_r.lan_cs;
  assign host_irq_line_out = st_r.irq;

  a_eof_sets_pend: assert property (@(posedge clk_in) disable iff (srst_in || !ce_in)
    eof_edge |=> st_r.pend_vld && st_r.pend_word[23:0] == $past(st_r.last_addr))
    else $error("frame end did not latch the last address");

  a_trailer_flag: assert property (@(posedge clk_in) disable iff (srst_in || !ce_in)
    eof_edge |=> st_r.pend_word[24] == ($past(st_r.word_cnt) >= 12'h004))
    else $error("trailer flag wrong");

  a_addr_latch: assert property (@(posedge clk_in) disable iff (srst_in || !ce_in)
    wr_done |=> st_r.last_addr == $past(st_r.s2_addr))
    else $error("receive write address not kept");

  a_cnt_clear: assert property (@(posedge clk_in) disable iff (srst_in || !ce_in)
    eof_edge |=> st_r.word_cnt == 12'h000)
    else $error("word count not restarted at frame end");

  a_coll_eop_pulse: assert property (@(posedge clk_in) disable iff (srst_in || !ce_in)
    (coll_edge && st_r.eop_st == ldg_pkg::LDG_EOP_IDLE) |=> end_of_process_strobe_out[*3] ##1 !end_of_process_strobe_out)
    else $error("end-of-process pulse not three cycles");

  a_eop_no_retrig: assert property (@(posedge clk_in) disable iff (srst_in || !ce_in)
    (st_r.eop_st == ldg_pkg::LDG_EOP_WAIT) |=> !end_of_process_strobe_out)
    else $error("end-of-process retriggered during collision");

  a_eop_idle_low: assert property (@(posedge clk_in) disable iff (srst_in || !ce_in)
    (st_r.eop_st == ldg_pkg::LDG_EOP_IDLE) |-> !end_of_process_strobe_out)
    else $error("end-of-process high while idle");

  a_tx_on_six: assert property (@(posedge clk_in) disable iff (srst_in || !ce_in)
    dma_req6_out |-> $past(st_r.s2_pin[`LDG_P_TXDRQ]))
    else $error("transmit request off its channel");

  a_rx_on_seven: assert property (@(posedge clk_in) disable iff (srst_in || !ce_in)
    dma_req7_out |-> $past(st_r.s2_pin[`LDG_P_RXDRQ]))
    else $error("receive request off its channel");

  a_irq_follows: assert property (@(posedge clk_in) disable iff (srst_in || !ce_in)
    host_irq_line_out == $past(st_r.s2_pin[`LDG_P_IRQ]))
    else $error("interrupt line does not follow controller");

  a_cs_decode: assert property (@(posedge clk_in) disable iff (srst_in || !ce_in)
    lan_cs_out |-> $past(sel_lan) && !$past(st_r.s2_pin[`LDG_P_AEN]))
    else $error("controller selected outside its window");

  a_oe_decode: assert property (@(posedge clk_in) disable iff (srst_in || !ce_in)
    bus_rdata_oe_out |-> $past(rd_act))
    else $error("read data driven outside a processor read");

  a_rx_stall: assert property (@(posedge clk_in) disable iff (srst_in || !ce_in)
    st_nxt.pend_vld |=> !dma_req7_out)
    else $error("receive request while frame end pending");

  a_pend_drains: assert property (@(posedge clk_in) disable iff (srst_in || !ce_in)
    (st_r.pend_vld && buf_in_ready && !eof_edge) |=> !st_r.pend_vld)
    else $error("pending frame end not stored");

  a_hold_limit: assert property (@(posedge clk_in) disable iff (srst_in || !ce_in)
    st_nxt.hold_block |=> !dma_req6_out && !dma_req7_out)
    else $error("bus tenure exceeded");

  a_hold_count: assert property (@(posedge clk_in) disable iff (srst_in || !ce_in)
    st_r.hold_cnt < 8'h96)
    else $error("tenure counter past its limit");

  a_latch_stable: assert property (@(posedge clk_in) disable iff (srst_in || !ce_in)
    (st_r.pend_vld && !buf_in_ready && !eof_edge) |=> $stable(st_r.pend_word))
    else $error("held end word changed");

endmodule : ldg_glue

// file: logic/ldg_map.svh
// Offsets, pin positions, reset values and timing counts of the LAN DMA glue
`ifndef LDG_MAP_SVH
`define LDG_MAP_SVH

// Host I/O decode, byte addresses on the 16-bit I/O space
`define LDG_LAN_IO_BASE 16'h0300
`define LDG_LAN_IO_MASK 16'hFFF8
`define LDG_LATCH_LO_ADDR 16'h0308
`define LDG_LATCH_HI_ADDR 16'h030A
`define LDG_STATUS_ADDR 16'h030C

// Positions in the synchronised pin vector
`define LDG_P_RXDRQ 0
`define LDG_P_TXDRQ 1
`define LDG_P_EOF 2
`define LDG_P_COLL 3
`define LDG_P_DACK6_N 4
`define LDG_P_DACK7_N 5
`define LDG_P_IORD_N 6
`define LDG_P_IOWR_N 7
`define LDG_P_AEN 8
`define LDG_P_MEMWR_N 9
`define LDG_P_IRQ 10
`define LDG_PIN_W 11

// Reset values; strobes are idle high
`define LDG_PIN_RST 11'h02F0
`define LDG_WORD_W 25
`define LDG_TRAILER_WORDS 12'h0004

// Timing
`define LDG_CLK_NS 100
`define LDG_EOP_NS 300
`define LDG_EOP_CYC ((`LDG_EOP_NS + `LDG_CLK_NS - 1) / `LDG_CLK_NS)
`define LDG_BUS_HOLD_NS 15000
`define LDG_BUS_HOLD_CYC (`LDG_BUS_HOLD_NS / `LDG_CLK_NS)
`define LDG_BUS_REST_NS 2000
`define LDG_BUS_REST_CYC (`LDG_BUS_REST_NS / `LDG_CLK_NS)

`endif

// file: logic/ldg_pkg.sv
// Types shared by the LAN DMA glue and its end-of-frame buffer
`include "ldg_map.svh"

package ldg_pkg;

  typedef logic [`LDG_WORD_W-1:0] ldg_word_t;
  typedef logic [`LDG_PIN_W-1:0] ldg_pins_t;

  typedef enum logic [1:0] {
    LDG_EOP_IDLE = 2'b00,
    LDG_EOP_PULSE = 2'b01,
    LDG_EOP_WAIT = 2'b10
  } ldg_eop_e;

  typedef struct packed {
    logic [1:0][`LDG_WORD_W-1:0] mem;
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] cnt;
  } ldg_buf_s;

  typedef struct packed {
    ldg_pins_t s1_pin;
    ldg_pins_t s2_pin;
    ldg_pins_t prev_pin;
    logic [23:0] s1_addr;
    logic [23:0] s2_addr;
    ldg_eop_e eop_st;
    logic [3:0] eop_cnt;
    logic [7:0] hold_cnt;
    logic [7:0] rest_cnt;
    logic hold_block;
    logic [23:0] last_addr;
    logic [11:0] word_cnt;
    logic pend_vld;
    ldg_word_t pend_word;
    logic [15:0] rdata;
    logic rdata_oe;
    logic lan_cs;
    logic drq6;
    logic drq7;
    logic eop;
    logic irq;
  } ldg_glue_s;

endpackage : ldg_pkg

// file: logic/ldg_buf.sv
// Two-entry buffer of end-of-frame words
`include "ldg_map.svh"

module ldg_buf (
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  // Fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire ldg_pkg::ldg_word_t in_data_in,
  // Drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output ldg_pkg::ldg_word_t out_data_out
);

  ldg_pkg::ldg_buf_s st_r;
  ldg_pkg::ldg_buf_s st_nxt;
  logic push;
  logic pop;

  assign in_ready_out = (st_r.cnt != 2'd2);
  assign out_valid_out = (st_r.cnt != 2'd0);
  assign out_data_out = st_r.mem[st_r.rd_ptr];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_ready_in && out_valid_out;

  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wr_ptr] = in_data_in;
      st_nxt.wr_ptr = ~st_r.wr_ptr;
    end
    if (pop) begin
      st_nxt.rd_ptr = ~st_r.rd_ptr;
    end
    // Entries never move, so an unread word stays put
    st_nxt.cnt = st_r.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      st_r <= '0;
    end else if (ce_in) begin
      st_r <= st_nxt;
    end
  end

  a_buf_count: assert property (@(posedge clk_in) disable iff (srst_in) st_r.cnt <= 2'd2)
    else $error("buffer count above two");

endmodule : ldg_buf

// file: tb/ldg_partner.sv
// Behavioural host DMA controller answering the glue's channel requests
module ldg_partner (
  // Clock and pacing
  input wire logic clk_in,
  input wire logic [3:0] gap_in,
  // Requests from the glue
  input wire logic req6_in,
  input wire logic req7_in,
  // Acknowledges and memory cycle
  output logic ack6_n_out,
  output logic ack7_n_out,
  output logic aen_out,
  output logic mem_wr_n_out,
  output logic [23:0] addr_out,
  output int words_out
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    ack6_n_out = 1'b1;
    ack7_n_out = 1'b1;
    aen_out = 1'b0;
    mem_wr_n_out = 1'b1;
    addr_out = 24'h01_2340;
    words_out = 0;
    forever begin
      @(posedge clk_in);
      #1;
      if (req7_in || req6_in) begin
        // Slow answers come from the gap before acknowledge
        repeat (gap_in) @(posedge clk_in);
        #1;
        aen_out = 1'b1;
        if (req7_in) begin
          ack7_n_out = 1'b0;
          while (req7_in) begin
            // Address moves only while the strobe is high
            addr_out = addr_out + 24'h00_0002;
            mem_wr_n_out = 1'b0;
            repeat (3) @(posedge clk_in);
            #1 mem_wr_n_out = 1'b1;
            words_out++;
            repeat (3) @(posedge clk_in);
            #1;
          end
        end else begin
          ack6_n_out = 1'b0;
          while (req6_in) begin
            @(posedge clk_in);
            #1;
          end
        end
        ack6_n_out = 1'b1;
        ack7_n_out = 1'b1;
        aen_out = 1'b0;
      end
    end
  end
endmodule : ldg_partner

// file: tb/lan_dma_handshake_glue_test.sv
// Self-checking bench of the LAN DMA glue against a host DMA model
`include "ldg_map.svh"
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin err_count++; \
  $display("MISMATCH %0t got %0h exp %0h", $time, got, exp); end end

module lan_dma_handshake_glue_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, srst, ce, rx_drq, tx_drq, eof, coll, irq, rd_n, io_wr_n;
  logic ack6_n, ack7_n, aen, wr_n, req6, req7, eop, oe, cs, irq_out;
  logic [23:0] io_addr, dma_addr;
  logic [15:0] rdata;
  logic [3:0] gap;
  int words, err_count, samples_checked;

  ldg_glue u_dut (.clk_in(clk), .srst_in(srst), .ce_in(ce), .lan_rx_drq_in(rx_drq),
    .lan_tx_drq_in(tx_drq), .lan_eof_in(eof), .lan_coll_in(coll), .lan_irq_in(irq),
    .dma_ack6_n_in(ack6_n), .dma_ack7_n_in(ack7_n), .dma_req6_out(req6), .dma_req7_out(req7),
    .end_of_process_strobe_out(eop), .bus_addr_in(aen ? dma_addr : io_addr), .bus_aen_in(aen),
    .io_rd_n_in(rd_n), .io_wr_n_in(io_wr_n), .mem_wr_n_in(wr_n), .bus_rdata_out(rdata),
    .bus_rdata_oe_out(oe), .lan_cs_out(cs), .host_irq_line_out(irq_out));

  ldg_partner u_host (.clk_in(clk), .gap_in(gap), .req6_in(req6), .req7_in(req7),
    .ack6_n_out(ack6_n), .ack7_n_out(ack7_n), .aen_out(aen), .mem_wr_n_out(wr_n),
    .addr_out(dma_addr), .words_out(words));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic end_of_test;
    if (err_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test

  // Only while DMA is idle: with the enable high the read is ignored
  task automatic io_read(input logic [15:0] a, output logic [15:0] d, output logic o, output logic c);
    io_addr = {8'h00, a};
    tick(1);
    rd_n = 1'b0;
    tick(5);
    d = rdata;
    o = oe;
    c = cs;
    rd_n = 1'b1;
    tick(6);
  endtask : io_read

  task automatic rx_frame(input int n, output logic [23:0] last, output logic ok);
    int w0;
    w0 = words;
    rx_drq = 1'b1;
    while (words < w0 + n) tick(1);
    rx_drq = 1'b0;
    while (req7 || !ack7_n) tick(1);
    last = dma_addr;
    ok = (words - w0) >= 4;
    eof = 1'b1;
    tick(4);
    eof = 1'b0;
    tick(6);
  endtask : rx_frame

  task automatic chk_entry(input logic [23:0] a, input logic ok);
    logic [15:0] d;
    logic o;
    logic c;
    io_read(`LDG_LATCH_LO_ADDR, d, o, c);
    `CHK(d, a[15:0])
    `CHK(o, 1'b1)
    io_read(`LDG_LATCH_LO_ADDR, d, o, c);
    `CHK(d, a[15:0])
    io_read(`LDG_LATCH_HI_ADDR, d, o, c);
    `CHK(d, {1'b1, 6'b00_0000, ok, a[23:16]})
  endtask : chk_entry

  task automatic t_chan;
    logic [15:0] d;
    logic o;
    logic c;
    // Enable low must freeze every pin stage
    ce = 1'b0;
    tx_drq = 1'b1;
    irq = 1'b1;
    tick(5);
    `CHK(req6, 1'b0)
    ce = 1'b1;
    tick(5);
    `CHK(req6, 1'b1)
    `CHK(req7, 1'b0)
    `CHK(irq_out, 1'b1)
    tx_drq = 1'b0;
    irq = 1'b0;
    tick(8);
    `CHK(irq_out, 1'b0)
    io_read(16'h0302, d, o, c);
    `CHK(c, 1'b1)
    io_read(16'h0310, d, o, c);
    `CHK(o, 1'b0)
    `CHK(c, 1'b0)
    io_addr = 24'h00_0304;
    tick(1);
    io_wr_n = 1'b0;
    tick(5);
    `CHK(cs, 1'b1)
    `CHK(oe, 1'b0)
    io_wr_n = 1'b1;
    tick(6);
    `CHK(cs, 1'b0)
  endtask : t_chan

  task automatic t_coll;
    int n;
    for (int i = 0; i < 2; i++) begin
      n = 0;
      coll = 1'b1;
      // Held high long enough to expose any retrigger
      repeat (20) begin
        tick(1);
        if (eop === 1'b1) n++;
      end
      coll = 1'b0;
      tick(5);
      `CHK(n, 3)
    end
  endtask : t_coll

  task automatic t_frames;
    logic [23:0] a0, a1, a2;
    logic k0, k1, k2, o, c;
    logic [15:0] d;
    rx_frame(5, a0, k0);
    gap = 4'h3;
    rx_frame(1, a1, k1);
    gap = 4'h0;
    rx_frame(1, a2, k2);
    rx_drq = 1'b1;
    tick(8);
    `CHK(req7, 1'b0)
    io_read(`LDG_STATUS_ADDR, d, o, c);
    `CHK(d, 16'h0003)
    chk_entry(a0, k0);
    tick(4);
    `CHK(req7, 1'b1)
    rx_drq = 1'b0;
    tick(2);
    while (!ack7_n) tick(1);
    chk_entry(a1, k1);
    chk_entry(a2, k2);
    io_read(`LDG_LATCH_HI_ADDR, d, o, c);
    `CHK(d[15], 1'b0)
  endtask : t_frames

  task automatic t_hold;
    int n;
    n = 0;
    tx_drq = 1'b1;
    while (ack6_n) tick(1);
    while (req6 && n < 400) begin
      tick(1);
      n++;
    end
    `CHK(n >= 150 && n <= 157, 1'b1)
    n = 0;
    while (!req6 && n < 400) begin
      tick(1);
      n++;
    end
    `CHK(n >= 20 && n <= 28, 1'b1)
    tx_drq = 1'b0;
    tick(10);
  endtask : t_hold

  initial begin
    err_count = 0;
    samples_checked = 0;
    {rx_drq, tx_drq, eof, coll, irq} = 5'h00;
    rd_n = 1'b1;
    io_wr_n = 1'b1;
    ce = 1'b1;
    io_addr = 24'h00_0000;
    gap = 4'h0;
    srst = 1'b1;
    tick(3);
    srst = 1'b0;
    tick(2);
    t_chan();
    t_coll();
    t_frames();
    t_hold();
    end_of_test();
  end

  // Whole run needs several hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    end_of_test();
  end
endmodule : lan_dma_handshake_glue_test
